// >>> src/dcfg_regs.sv
// datapath configuration register bank with axi4-lite slave
//
// Decided for this implementation: the AXI4-Lite interface to the registers.
`timescale 1ns/1ps
`include "dcfg_defs.svh"

module dcfg_regs
	import dcfg_pkg::*;
(
	// clock and reset
	input  wire logic        aclk,
	input  wire logic        aresetn,
	// axi4-lite write address, data and response
	input  wire logic [7:0]  s_axi_awaddr,
	input  wire logic        s_axi_awvalid,
	output logic             s_axi_awready,
	input  wire logic [31:0] s_axi_wdata,
	input  wire logic [3:0]  s_axi_wstrb,
	input  wire logic        s_axi_wvalid,
	output logic             s_axi_wready,
	output logic [1:0]       s_axi_bresp,
	output logic             s_axi_bvalid,
	input  wire logic        s_axi_bready,
	// axi4-lite read
	input  wire logic [7:0]  s_axi_araddr,
	input  wire logic        s_axi_arvalid,
	output logic             s_axi_arready,
	output logic [31:0]      s_axi_rdata,
	output logic [1:0]       s_axi_rresp,
	output logic             s_axi_rvalid,
	input  wire logic        s_axi_rready,
	// pins
	input  wire logic        sync_pin,
	input  wire logic        transmit_gate_pin,
	input  wire logic        pll_locked,
	input  wire logic        int_clock_gen,
	output logic             shared_clock_pin_o,
	output logic             shared_clock_pin_oe,
	output logic             shared_lock_clock_pin_o,
	output logic             shared_lock_clock_pin_oe,
	// clock control
	output logic             diff_clock_select,
	output logic             single_ended_clock_level,
	output logic [1:0]       diff_clock_delay,
	output logic [1:0]       se_clock_delay,
	output logic             four_wire_select,
	output logic             divider_sync_pulse,
	output logic [3:0]       divider_phase,
	// datapath
	output logic [15:0]      dac_a_out,
	output logic [15:0]      dac_b_out,
	output logic [15:0]      nco_lut_addr
);

	////////////////////////////////////////////////////////////////
	// registers
	logic [7:0]  clkpin_r, clkdly_r, route_r, sync_r;
	logic [15:0] phofs_r, serdata_r;
	logic [31:0] fword_r;
	dcfg_pair_t  smp_in_r;
	logic [7:0]  aw_addr_r, ar_addr_r;
	logic        aw_have_r, w_have_r;
	logic [31:0] w_data_r;
	logic [3:0]  w_strb_r;
	logic        do_wr;

	function automatic logic mapped(input logic [7:0] a);
		case (a)
			`DCFG_OFF_CLKPIN, `DCFG_OFF_CLKDLY, `DCFG_OFF_ROUTE, `DCFG_OFF_SYNC,
			`DCFG_OFF_PH_LO, `DCFG_OFF_PH_HI, `DCFG_OFF_FW0, `DCFG_OFF_FW1,
			`DCFG_OFF_FW2, `DCFG_OFF_FW3, `DCFG_OFF_SMP_A, `DCFG_OFF_SMP_B,
			`DCFG_OFF_SERDATA, `DCFG_OFF_STAT: mapped = 1'b1;
			default: mapped = 1'b0;
		endcase
	endfunction

	function automatic logic [15:0] rev16(input logic [15:0] v);
		for (int i = 0; i < 16; i++) begin
			rev16[i] = v[15-i];
		end
	endfunction

	////////////////////////////////////////////////////////////////
	// axi write channel
	assign do_wr = aw_have_r && w_have_r && !s_axi_bvalid;

	always_ff @(posedge aclk) begin
		if (!aresetn) begin
			aw_have_r     <= 1'b0;
			w_have_r      <= 1'b0;
			aw_addr_r     <= 8'h00;
			w_data_r      <= 32'h0000_0000;
			w_strb_r      <= 4'h0;
			s_axi_awready <= 1'b0;
			s_axi_wready  <= 1'b0;
			s_axi_bvalid  <= 1'b0;
			s_axi_bresp   <= 2'b00;
		end else begin
			s_axi_awready <= !aw_have_r && !s_axi_awready && s_axi_awvalid;
			s_axi_wready  <= !w_have_r && !s_axi_wready && s_axi_wvalid;
			if (s_axi_awvalid && s_axi_awready) begin
				aw_have_r <= 1'b1;
				aw_addr_r <= s_axi_awaddr;
			end
			if (s_axi_wvalid && s_axi_wready) begin
				w_have_r <= 1'b1;
				w_data_r <= s_axi_wdata;
				w_strb_r <= s_axi_wstrb;
			end
			if (do_wr) begin
				aw_have_r    <= 1'b0;
				w_have_r     <= 1'b0;
				s_axi_bvalid <= 1'b1;
				s_axi_bresp  <= mapped(aw_addr_r) ? 2'b00 : 2'b10;
			end else if (s_axi_bvalid && s_axi_bready) begin
				s_axi_bvalid <= 1'b0;
			end
		end
	end

	////////////////////////////////////////////////////////////////
	// register writes
	always_ff @(posedge aclk) begin
		if (!aresetn) begin
			clkpin_r  <= `DCFG_RST_CLKPIN;
			clkdly_r  <= `DCFG_RST_CLKDLY;
			route_r   <= `DCFG_RST_ROUTE;
			sync_r    <= `DCFG_RST_SYNC;
			phofs_r   <= 16'h0000;
			fword_r   <= 32'h0000_0000;
			serdata_r <= 16'h0000;
			smp_in_r  <= '0;
		end else if (do_wr) begin
			if (w_strb_r[0]) begin
				case (aw_addr_r)
					`DCFG_OFF_CLKPIN:  clkpin_r <= w_data_r[7:0];
					`DCFG_OFF_CLKDLY:  clkdly_r <= {w_data_r[7:4], 4'h0};
					`DCFG_OFF_ROUTE:   route_r  <= {w_data_r[7:3], 1'b0, w_data_r[1:0]};
					`DCFG_OFF_SYNC:    sync_r   <= {w_data_r[7:4], 1'b0, w_data_r[2:1], 1'b0};
					`DCFG_OFF_PH_LO:   phofs_r[7:0]    <= w_data_r[7:0];
					`DCFG_OFF_PH_HI:   phofs_r[15:8]   <= w_data_r[7:0];
					`DCFG_OFF_FW0:     fword_r[7:0]    <= w_data_r[7:0];
					`DCFG_OFF_FW1:     fword_r[15:8]   <= w_data_r[7:0];
					`DCFG_OFF_FW2:     fword_r[23:16]  <= w_data_r[7:0];
					`DCFG_OFF_FW3:     fword_r[31:24]  <= w_data_r[7:0];
					`DCFG_OFF_SMP_A:   smp_in_r.a[7:0] <= w_data_r[7:0];
					`DCFG_OFF_SMP_B:   smp_in_r.b[7:0] <= w_data_r[7:0];
					`DCFG_OFF_SERDATA: serdata_r[7:0]  <= w_data_r[7:0];
					default: ;
				endcase
			end
			if (w_strb_r[1]) begin
				case (aw_addr_r)
					`DCFG_OFF_SMP_A:   smp_in_r.a[15:8] <= w_data_r[15:8];
					`DCFG_OFF_SMP_B:   smp_in_r.b[15:8] <= w_data_r[15:8];
					`DCFG_OFF_SERDATA: serdata_r[15:8]  <= w_data_r[15:8];
					default: ;
				endcase
			end
		end
	end

	////////////////////////////////////////////////////////////////
	// axi read channel
	logic [31:0] rd_mux;
	always_comb begin
		case (ar_addr_r)
			`DCFG_OFF_CLKPIN:  rd_mux = {24'h0, clkpin_r};
			`DCFG_OFF_CLKDLY:  rd_mux = {24'h0, clkdly_r};
			`DCFG_OFF_ROUTE:   rd_mux = {24'h0, route_r};
			`DCFG_OFF_SYNC:    rd_mux = {24'h0, sync_r};
			`DCFG_OFF_PH_LO:   rd_mux = {24'h0, phofs_r[7:0]};
			`DCFG_OFF_PH_HI:   rd_mux = {24'h0, phofs_r[15:8]};
			`DCFG_OFF_FW0:     rd_mux = {24'h0, fword_r[7:0]};
			`DCFG_OFF_FW1:     rd_mux = {24'h0, fword_r[15:8]};
			`DCFG_OFF_FW2:     rd_mux = {24'h0, fword_r[23:16]};
			`DCFG_OFF_FW3:     rd_mux = {24'h0, fword_r[31:24]};
			`DCFG_OFF_SMP_A:   rd_mux = {16'h0, smp_in_r.a};
			`DCFG_OFF_SMP_B:   rd_mux = {16'h0, smp_in_r.b};
			`DCFG_OFF_SERDATA: rd_mux = {16'h0, serdata_r};
			`DCFG_OFF_STAT:    rd_mux = {12'h0, divider_phase, nco_lut_addr};
			default:           rd_mux = 32'h0000_0000;
		endcase
	end

	logic ar_have_r;
	always_ff @(posedge aclk) begin
		if (!aresetn) begin
			ar_have_r     <= 1'b0;
			ar_addr_r     <= 8'h00;
			s_axi_arready <= 1'b0;
			s_axi_rvalid  <= 1'b0;
			s_axi_rdata   <= 32'h0000_0000;
			s_axi_rresp   <= 2'b00;
		end else begin
			s_axi_arready <= !ar_have_r && !s_axi_arready && !s_axi_rvalid && s_axi_arvalid;
			if (s_axi_arvalid && s_axi_arready) begin
				ar_have_r <= 1'b1;
				ar_addr_r <= s_axi_araddr;
			end
			if (ar_have_r) begin
				ar_have_r    <= 1'b0;
				s_axi_rvalid <= 1'b1;
				s_axi_rdata  <= rd_mux;
				s_axi_rresp  <= mapped(ar_addr_r) ? 2'b00 : 2'b10;
			end else if (s_axi_rvalid && s_axi_rready) begin
				s_axi_rvalid <= 1'b0;
			end
		end
	end

	////////////////////////////////////////////////////////////////
	// pin synchronisers
	logic [1:0] sync_meta_r, sync_s_r;
	logic       sel_d_r, swsync_d_r;
	always_ff @(posedge aclk) begin
		if (!aresetn) begin
			sync_meta_r <= 2'b00;
			sync_s_r    <= 2'b00;
		end else begin
			sync_meta_r <= {transmit_gate_pin, sync_pin};
			sync_s_r    <= sync_meta_r;
		end
	end

	////////////////////////////////////////////////////////////////
	// clock pin control
	always_ff @(posedge aclk) begin
		if (!aresetn) begin
			diff_clock_select        <= 1'b1;
			single_ended_clock_level <= 1'b1;
			shared_clock_pin_o       <= 1'b0;
			shared_clock_pin_oe      <= 1'b0;
			shared_lock_clock_pin_o  <= 1'b0;
			shared_lock_clock_pin_oe <= 1'b0;
		end else begin
			diff_clock_select        <= clkpin_r[`DCFG_B_DIFFCLK];
			single_ended_clock_level <= clkpin_r[`DCFG_B_SEFREEZE] ? 1'b1 : int_clock_gen;
			shared_clock_pin_oe      <= !clkpin_r[`DCFG_B_MAININ];
			shared_clock_pin_o       <= int_clock_gen;
			shared_lock_clock_pin_oe <= !clkpin_r[`DCFG_B_NEGIN];
			shared_lock_clock_pin_o  <= pll_locked;
		end
	end

	////////////////////////////////////////////////////////////////
	// clock delays and serial width
	always_ff @(posedge aclk) begin
		if (!aresetn) begin
			diff_clock_delay <= 2'b00;
			se_clock_delay   <= 2'b00;
			four_wire_select <= 1'b0;
		end else begin
			diff_clock_delay <= clkdly_r[7:6];
			se_clock_delay   <= clkdly_r[5:4];
			four_wire_select <= sync_r[`DCFG_B_FOURW];
		end
	end

	////////////////////////////////////////////////////////////////
	// divider sync and slip
	logic sel_s;
	logic sel_rise;
	assign sel_s = sync_r[`DCFG_B_DSYNC_SEL] ? sync_s_r[1] : sync_s_r[0];
	assign sel_rise = sel_s && !sel_d_r;
	always_ff @(posedge aclk) begin
		if (!aresetn) begin
			sel_d_r            <= 1'b0;
			swsync_d_r         <= 1'b0;
			divider_sync_pulse <= 1'b0;
			divider_phase      <= 4'h0;
		end else begin
			sel_d_r    <= sel_s;
			swsync_d_r <= sync_r[`DCFG_B_SWSYNC];
			divider_sync_pulse <= (sync_r[`DCFG_B_DSYNC_EN] && sel_rise)
				|| (sync_r[`DCFG_B_SWSYNC] && !swsync_d_r);
			if (sync_r[`DCFG_B_DSYNC_EN] && sel_rise && !sync_r[`DCFG_B_DSHIFT]) begin
				divider_phase <= 4'h0;
			end else if (sync_r[`DCFG_B_DSHIFT] && sel_rise) begin
				divider_phase <= divider_phase;
			end else if (divider_phase == `DCFG_DIV_LEN - 4'd1) begin
				divider_phase <= 4'h0;
			end else begin
				divider_phase <= divider_phase + 4'd1;
			end
		end
	end

	////////////////////////////////////////////////////////////////
	// oscillator
	logic [31:0] acc_r;
	always_ff @(posedge aclk) begin
		if (!aresetn) begin
			acc_r        <= 32'h0000_0000;
			nco_lut_addr <= 16'h0000;
		end else begin
			acc_r        <= acc_r + fword_r;
			nco_lut_addr <= acc_r[31:16] + phofs_r;
		end
	end

	////////////////////////////////////////////////////////////////
	// datapath
	dcfg_pair_t  s0, s1, s2, s3;
	dcfg_pair_t  dly_r [3];
	dcfg_route_t rt;
	logic signed [16:0] mix_a, mix_b;
	always_comb begin
		s0.a = route_r[`DCFG_B_REVA] ? rev16(smp_in_r.a) : smp_in_r.a;
		s0.b = route_r[`DCFG_B_REVB] ? rev16(smp_in_r.b) : smp_in_r.b;
		s1.a = s0.a + (clkpin_r[`DCFG_B_QOFS] ? 16'h0001 : 16'h0000);
		s1.b = s0.b + (clkpin_r[`DCFG_B_QOFS] ? 16'h0001 : 16'h0000);
		s1.a = clkpin_r[`DCFG_B_QCORR] ? s1.a - {{3{s1.b[15]}}, s1.b[15:3]} : s1.a;
		s1.a = clkpin_r[`DCFG_B_ISINC] ? s1.a + {{4{s1.a[15]}}, s1.a[15:4]} : s1.a;
		s1.b = clkpin_r[`DCFG_B_ISINC] ? s1.b + {{4{s1.b[15]}}, s1.b[15:4]} : s1.b;
		mix_a = clkpin_r[`DCFG_B_MIXER] && nco_lut_addr[15] ? -$signed({s1.a[15], s1.a}) : $signed({s1.a[15], s1.a});
		mix_b = clkpin_r[`DCFG_B_MIXER] && nco_lut_addr[15] ? -$signed({s1.b[15], s1.b}) : $signed({s1.b[15], s1.b});
		s2.a = (clkpin_r[`DCFG_B_MIXER] && sync_r[`DCFG_B_MIXGAIN]) ? 16'(mix_a <<< 1) : 16'(mix_a);
		s2.b = (clkpin_r[`DCFG_B_MIXER] && sync_r[`DCFG_B_MIXGAIN]) ? 16'(mix_b <<< 1) : 16'(mix_b);
		rt = dcfg_route_t'({route_r[`DCFG_B_BEQA], route_r[`DCFG_B_AEQB]});
		unique case (rt)
			DCFG_RT_NORMAL: s3 = s2;
			DCFG_RT_BOTH_B: s3 = '{a: s2.b, b: s2.b};
			DCFG_RT_BOTH_A: s3 = '{a: s2.a, b: s2.a};
			DCFG_RT_SWAP:   s3 = '{a: s2.b, b: s2.a};
		endcase
		if (route_r[`DCFG_B_SERTEST]) begin
			s3 = '{a: serdata_r, b: serdata_r};
		end
	end

	always_ff @(posedge aclk) begin
		if (!aresetn) begin
			dly_r[0] <= '0;
			dly_r[1] <= '0;
			dly_r[2] <= '0;
		end else begin
			dly_r[0] <= s3;
			dly_r[1] <= dly_r[0];
			dly_r[2] <= dly_r[1];
		end
	end

	////////////////////////////////////////////////////////////////
	// converter outputs
	always_ff @(posedge aclk) begin
		if (!aresetn) begin
			dac_a_out <= 16'h0000;
			dac_b_out <= 16'h0000;
		end else begin
			unique case (route_r[`DCFG_B_ODLY_HI:`DCFG_B_ODLY_LO])
				2'd0: {dac_a_out, dac_b_out} <= s3;
				2'd1: {dac_a_out, dac_b_out} <= dly_r[0];
				2'd2: {dac_a_out, dac_b_out} <= dly_r[1];
				2'd3: {dac_a_out, dac_b_out} <= dly_r[2];
			endcase
		end
	end

endmodule

// >>> src/dcfg_defs.svh
// offsets, field positions, reset values and timing counts of the datapath configuration bank
`ifndef DCFG_DEFS_SVH
`define DCFG_DEFS_SVH

`define DCFG_IDX_CLKPIN   8'h02
`define DCFG_IDX_CLKDLY   8'h03
`define DCFG_IDX_ROUTE    8'h04
`define DCFG_IDX_SYNC     8'h05
`define DCFG_IDX_PH_LO    8'h06
`define DCFG_IDX_PH_HI    8'h07
`define DCFG_IDX_FW0      8'h08
`define DCFG_IDX_FW1      8'h09
`define DCFG_IDX_FW2      8'h0a
`define DCFG_IDX_FW3      8'h0b

`define DCFG_OFF_CLKPIN   (`DCFG_IDX_CLKPIN << 2)
`define DCFG_OFF_CLKDLY   (`DCFG_IDX_CLKDLY << 2)
`define DCFG_OFF_ROUTE    (`DCFG_IDX_ROUTE << 2)
`define DCFG_OFF_SYNC     (`DCFG_IDX_SYNC << 2)
`define DCFG_OFF_PH_LO    (`DCFG_IDX_PH_LO << 2)
`define DCFG_OFF_PH_HI    (`DCFG_IDX_PH_HI << 2)
`define DCFG_OFF_FW0      (`DCFG_IDX_FW0 << 2)
`define DCFG_OFF_FW1      (`DCFG_IDX_FW1 << 2)
`define DCFG_OFF_FW2      (`DCFG_IDX_FW2 << 2)
`define DCFG_OFF_FW3      (`DCFG_IDX_FW3 << 2)
`define DCFG_OFF_SMP_A    8'h40
`define DCFG_OFF_SMP_B    8'h44
`define DCFG_OFF_SERDATA  8'h48
`define DCFG_OFF_STAT     8'h4c

`define DCFG_RST_CLKPIN   8'he1
`define DCFG_RST_CLKDLY   8'h00
`define DCFG_RST_ROUTE    8'h00
`define DCFG_RST_SYNC     8'h22

`define DCFG_B_DIFFCLK    7
`define DCFG_B_MAININ     6
`define DCFG_B_NEGIN      5
`define DCFG_B_SEFREEZE   4
`define DCFG_B_ISINC      3
`define DCFG_B_QOFS       2
`define DCFG_B_QCORR      1
`define DCFG_B_MIXER      0
`define DCFG_B_SERTEST    7
`define DCFG_B_ODLY_HI    6
`define DCFG_B_ODLY_LO    5
`define DCFG_B_BEQA       4
`define DCFG_B_AEQB       3
`define DCFG_B_REVA       1
`define DCFG_B_REVB       0
`define DCFG_B_FOURW      7
`define DCFG_B_SWSYNC     6
`define DCFG_B_DSYNC_EN   5
`define DCFG_B_DSYNC_SEL  4
`define DCFG_B_DSHIFT     2
`define DCFG_B_MIXGAIN    1

`define DCFG_DLY_STEP_NS  1.0
`define DCFG_CLK_NS       50.0
`define DCFG_DIV_LEN      4'd8

`endif

// >>> src/dcfg_pkg.sv
// types of the datapath configuration bank
package dcfg_pkg;
	typedef struct packed {
		logic [15:0] a;
		logic [15:0] b;
	} dcfg_pair_t;
	typedef enum logic [1:0] {
		DCFG_RT_NORMAL,
		DCFG_RT_BOTH_B,
		DCFG_RT_BOTH_A,
		DCFG_RT_SWAP
	} dcfg_route_t;
endpackage

// >>> testbench/dcfg_properties.sv
// port checks of the configuration bank
`timescale 1ns/1ps
`include "dcfg_defs.svh"
module dcfg_properties (
	// clock and reset
	input wire logic       aclk,
	input wire logic       aresetn,
	// register bus
	input wire logic       s_axi_arvalid,
	input wire logic       s_axi_arready,
	input wire logic       s_axi_rvalid,
	input wire logic       s_axi_rready,
	input wire logic       s_axi_bvalid,
	input wire logic       s_axi_bready,
	// pins
	input wire logic       pll_locked,
	input wire logic       int_clock_gen,
	input wire logic       shared_clock_pin_o,
	input wire logic       shared_clock_pin_oe,
	input wire logic       shared_lock_clock_pin_o,
	input wire logic       shared_lock_clock_pin_oe,
	input wire logic       single_ended_clock_level,
	input wire logic       divider_sync_pulse,
	input wire logic [3:0] divider_phase
);
	default clocking cb @(posedge aclk); endclocking
	default disable iff (!aresetn);
	////////////////////////////////////////////////////////////
	a_clk_pin_drive: assert property (
		shared_clock_pin_oe && $past(shared_clock_pin_oe) |-> shared_clock_pin_o == $past(int_clock_gen))
		else $error("shared clock pin not following clock");
	a_lock_pin_drive: assert property (
		shared_lock_clock_pin_oe && $past(shared_lock_clock_pin_oe) |-> shared_lock_clock_pin_o == $past(pll_locked))
		else $error("lock pin not following lock");
	a_freeze_level: assert property (
		!single_ended_clock_level |-> !$past(int_clock_gen))
		else $error("single ended level low without cause");
	a_sync_pulse_one: assert property (
		divider_sync_pulse |=> !divider_sync_pulse)
		else $error("sync pulse longer than one cycle");
	a_phase_wrap: assert property (
		divider_phase < `DCFG_DIV_LEN)
		else $error("divider phase out of range");
	a_read_answer: assert property (
		s_axi_arvalid && s_axi_arready |-> ##[1:4] s_axi_rvalid)
		else $error("read answer late");
	a_rresp_once: assert property (
		s_axi_rvalid && s_axi_rready |=> !s_axi_rvalid)
		else $error("read answer repeated");
	a_bresp_once: assert property (
		s_axi_bvalid && s_axi_bready |=> !s_axi_bvalid)
		else $error("write answer repeated");
endmodule
bind dcfg_regs dcfg_properties u_props (.*);

// >>> testbench/dcfg_host.sv
// axi4-lite host model for the configuration bank
`timescale 1ns/1ps
`include "dcfg_defs.svh"
module dcfg_host (
	// clock
	input wire logic        aclk,
	// write
	output logic [7:0]      s_axi_awaddr,
	output logic            s_axi_awvalid,
	input wire logic        s_axi_awready,
	output logic [31:0]     s_axi_wdata,
	output logic [3:0]      s_axi_wstrb,
	output logic            s_axi_wvalid,
	input wire logic        s_axi_wready,
	input wire logic [1:0]  s_axi_bresp,
	input wire logic        s_axi_bvalid,
	output logic            s_axi_bready,
	// read
	output logic [7:0]      s_axi_araddr,
	output logic            s_axi_arvalid,
	input wire logic        s_axi_arready,
	input wire logic [31:0] s_axi_rdata,
	input wire logic [1:0]  s_axi_rresp,
	input wire logic        s_axi_rvalid,
	output logic            s_axi_rready
);
	initial begin
		{s_axi_awvalid, s_axi_wvalid, s_axi_bready, s_axi_arvalid, s_axi_rready} = '0;
		{s_axi_awaddr, s_axi_wdata, s_axi_wstrb, s_axi_araddr} = '0;
	end
	////////////////////////////////////////////////////////////
	task automatic wr(input logic [7:0] a, input logic [31:0] d, output logic [1:0] r);
		logic aw;
		logic wd;
		@(posedge aclk);
		s_axi_awaddr <= a;
		s_axi_wdata <= d;
		s_axi_wstrb <= 4'hf;
		s_axi_awvalid <= 1'b1;
		s_axi_wvalid <= 1'b1;
		s_axi_bready <= 1'b1;
		aw = 1'b0;
		wd = 1'b0;
		while (!(aw && wd)) begin
			@(posedge aclk);
			if (!aw && s_axi_awready) begin
				aw = 1'b1;
				s_axi_awvalid <= 1'b0;
				s_axi_awaddr <= ~a;
			end
			if (!wd && s_axi_wready) begin
				wd = 1'b1;
				s_axi_wvalid <= 1'b0;
				s_axi_wdata <= ~d;
			end
		end
		while (!s_axi_bvalid) @(posedge aclk);
		r = s_axi_bresp;
		s_axi_bready <= 1'b0;
	endtask
	task automatic rd(input logic [7:0] a, output logic [31:0] d, output logic [1:0] r);
		@(posedge aclk);
		s_axi_araddr <= a;
		s_axi_arvalid <= 1'b1;
		s_axi_rready <= 1'b1;
		@(posedge aclk);
		while (!s_axi_arready) @(posedge aclk);
		s_axi_arvalid <= 1'b0;
		s_axi_araddr <= ~a;
		@(posedge aclk);
		while (!s_axi_rvalid) @(posedge aclk);
		d = s_axi_rdata;
		r = s_axi_rresp;
		s_axi_rready <= 1'b0;
	endtask
	// software sync: set the bit, then clear it
	task automatic sync_pulse(input logic [7:0] v);
		logic [1:0] r;
		wr(`DCFG_OFF_SYNC, {24'h0, v | 8'h40}, r);
		wr(`DCFG_OFF_SYNC, {24'h0, v & 8'hbf}, r);
	endtask
endmodule

// >>> testbench/tb.sv
// testbench of the configuration bank
`timescale 1ns/1ps
`include "dcfg_defs.svh"
module tb;
	logic aclk, aresetn, sync_pin, transmit_gate_pin, pll_locked, int_clock_gen;
	logic [7:0] s_axi_awaddr, s_axi_araddr;
	logic [31:0] s_axi_wdata, s_axi_rdata;
	logic [3:0] s_axi_wstrb, divider_phase, tick = '0;
	logic s_axi_awvalid, s_axi_awready, s_axi_wvalid, s_axi_wready, s_axi_bvalid, s_axi_bready;
	logic s_axi_arvalid, s_axi_arready, s_axi_rvalid, s_axi_rready;
	logic [1:0] s_axi_bresp, s_axi_rresp, diff_clock_delay, se_clock_delay;
	logic shared_clock_pin_o, shared_clock_pin_oe, shared_lock_clock_pin_o, shared_lock_clock_pin_oe;
	logic diff_clock_select, single_ended_clock_level, four_wire_select, divider_sync_pulse;
	logic [15:0] dac_a_out, dac_b_out, nco_lut_addr;
	int mismatches = 0;
	int n_checks = 0;
	int npulse = 0;
	dcfg_regs dut (.*);
	dcfg_host host (.*);
	assign int_clock_gen = tick[0];
	assign pll_locked = tick[2];
	initial begin
		aclk = 1'b0;
		forever #25 aclk = ~aclk;
	end
	always @(posedge aclk) begin
		tick <= tick + 4'h1;
		if (divider_sync_pulse === 1'b1) npulse <= npulse + 1;
	end
	////////////////////////////////////////////////////////////
	task automatic summarize;
		$display("mismatches=%0d n_checks=%0d", mismatches, n_checks);
		if (mismatches == 0 && n_checks > 0) begin
			$display("All checks passed");
		end else begin
			$display("Checks failed");
		end
		$finish;
	endtask
	task automatic chk(input logic [31:0] g, input logic [31:0] e);
		n_checks++;
		if (g !== e) begin
			mismatches++;
			$display("[ERR] t=%0t got %h exp %h", $time, g, e);
		end
	endtask
	task automatic w(input logic [7:0] a, input logic [31:0] d);
		logic [1:0] r;
		host.wr(a, d, r);
		chk(r, 32'h0);
	endtask
	task automatic rc(input logic [7:0] a, input logic [31:0] e, input logic [1:0] er);
		logic [31:0] d;
		logic [1:0] r;
		host.rd(a, d, r);
		chk(d, e);
		chk(r, er);
	endtask
	task automatic pin_pulse(input logic tx, input int e);
		int p;
		p = npulse;
		if (tx) transmit_gate_pin <= 1'b1;
		else sync_pin <= 1'b1;
		repeat (8) @(posedge aclk);
		sync_pin <= 1'b0;
		transmit_gate_pin <= 1'b0;
		repeat (8) @(posedge aclk);
		chk(npulse - p, e);
	endtask
	task automatic phase_chk(input logic [3:0] e, input logic rel);
		logic [3:0] p;
		@(posedge aclk);
		p = divider_phase;
		sync_pin <= 1'b1;
		repeat (6) @(posedge aclk);
		chk(rel ? 4'(divider_phase - p) & 4'h7 : divider_phase, e);
		sync_pin <= 1'b0;
		repeat (4) @(posedge aclk);
	endtask
	initial begin
		repeat (20000) @(posedge aclk);
		mismatches++;
		summarize();
	end
	////////////////////////////////////////////////////////////
	initial begin
		logic [1:0] r;
		logic [31:0] d;
		logic [15:0] a0;
		int n;
		int n0;
		aresetn = 1'b0;
		sync_pin = 1'b0;
		transmit_gate_pin = 1'b0;
		repeat (16) @(posedge aclk);
		aresetn <= 1'b1;
		chk(diff_clock_select, 1);
		for (int i = 0; i < 10; i++) begin
			rc(`DCFG_OFF_CLKPIN + 8'(4*i), (i == 0) ? 8'he1 : (i == 3) ? 8'h22 : 8'h00, 2'b00);
			w(`DCFG_OFF_CLKPIN + 8'(4*i), 32'h5a);
			rc(`DCFG_OFF_CLKPIN + 8'(4*i), 8'h5a & ((i == 1) ? 8'hf0 : (i == 2) ? 8'hfb : (i == 3) ? 8'hf6 : 8'hff), 2'b00);
		end
		rc(8'h80, 32'h0, 2'b10);
		host.wr(8'h84, 32'h1, r);
		chk(r, 2'b10);
		w(`DCFG_OFF_CLKPIN, 32'h10);
		repeat (4) @(posedge aclk);
		chk({diff_clock_select, shared_clock_pin_oe, shared_lock_clock_pin_oe}, 3'b011);
		chk(single_ended_clock_level, 1);
		w(`DCFG_OFF_CLKPIN, 32'he0);
		repeat (4) @(posedge aclk);
		chk({diff_clock_select, shared_clock_pin_oe, shared_lock_clock_pin_oe}, 3'b100);
		for (int c = 0; c < 4; c++) begin
			w(`DCFG_OFF_CLKDLY, {24'h0, c[1:0], ~c[1:0], 4'h0});
			repeat (3) @(posedge aclk);
			chk({diff_clock_delay, se_clock_delay}, {c[1:0], ~c[1:0]});
		end
		w(`DCFG_OFF_SMP_A, 32'h1234);
		w(`DCFG_OFF_SMP_B, 32'hc001);
		for (int m = 0; m < 4; m++) begin
			w(`DCFG_OFF_ROUTE, 32'(m << 3));
			repeat (8) @(posedge aclk);
			chk({dac_a_out, dac_b_out}, {m[0] ? 16'hc001 : 16'h1234, m[1] ? 16'h1234 : 16'hc001});
		end
		w(`DCFG_OFF_ROUTE, 32'h03);
		repeat (8) @(posedge aclk);
		chk({dac_a_out, dac_b_out}, {16'h2c48, 16'h8003});
		for (int k = 0; k < 4; k++) begin
			w(`DCFG_OFF_ROUTE, 32'(k << 5));
			repeat (8) @(posedge aclk);
			n = 0;
			fork
				w(`DCFG_OFF_SMP_A, 32'h0100 + 32'(k));
				while (dac_a_out !== 16'h0100 + 16'(k) && n < 40) begin
					@(posedge aclk);
					n++;
				end
			join
			if (k == 0) n0 = n;
			chk(n, n0 + k);
		end
		w(`DCFG_OFF_SERDATA, 32'hbeef);
		w(`DCFG_OFF_ROUTE, 32'h98);
		repeat (8) @(posedge aclk);
		chk({dac_a_out, dac_b_out}, {2{16'hbeef}});
		w(`DCFG_OFF_ROUTE, 32'h0);
		w(`DCFG_OFF_CLKPIN, 32'he4);
		repeat (8) @(posedge aclk);
		chk(dac_a_out, 16'h0104);
		w(`DCFG_OFF_SYNC, 32'h20);
		repeat (3) @(posedge aclk);
		chk(four_wire_select, 0);
		pin_pulse(1'b0, 1);
		pin_pulse(1'b1, 0);
		w(`DCFG_OFF_SYNC, 32'h30);
		pin_pulse(1'b1, 1);
		pin_pulse(1'b0, 0);
		n = npulse;
		host.sync_pulse(8'h20);
		repeat (8) @(posedge aclk);
		chk(npulse - n, 1);
		w(`DCFG_OFF_SYNC, 32'h80);
		repeat (3) @(posedge aclk);
		chk(four_wire_select, 1);
		for (int i = 0; i < 4; i++) w(`DCFG_OFF_FW0 + 8'(4*i), 32'h0);
		repeat (4) @(posedge aclk);
		a0 = nco_lut_addr;
		w(`DCFG_OFF_PH_LO, 32'h34);
		w(`DCFG_OFF_PH_HI, 32'h12);
		repeat (4) @(posedge aclk);
		chk(nco_lut_addr, 16'(a0 - 16'h5a5a + 16'h1234));
		w(`DCFG_OFF_FW2, 32'hff);
		@(posedge aclk);
		a0 = nco_lut_addr;
		repeat (5) @(posedge aclk);
		chk(16'(nco_lut_addr - a0), 16'h04fb);
		w(`DCFG_OFF_FW3, 32'hff);
		@(posedge aclk);
		a0 = nco_lut_addr;
		repeat (5) @(posedge aclk);
		chk(16'(nco_lut_addr - a0), 16'hfffb);
		aresetn <= 1'b0;
		repeat (2) @(posedge aclk);
		aresetn <= 1'b1;
		rc(`DCFG_OFF_CLKPIN, 32'he1, 2'b00);
		chk(single_ended_clock_level, !int_clock_gen);
		w(`DCFG_OFF_SMP_A, 32'h0100);
		w(`DCFG_OFF_SMP_B, 32'h0200);
		repeat (4) @(posedge aclk);
		chk({dac_a_out, dac_b_out}, {16'h0200, 16'h0400});
		phase_chk(4'h2, 1'b0);
		w(`DCFG_OFF_SYNC, 32'h26);
		phase_chk(4'h5, 1'b1);
		w(`DCFG_OFF_PH_HI, 32'h80);
		repeat (4) @(posedge aclk);
		chk(nco_lut_addr, 16'h8000);
		chk({dac_a_out, dac_b_out}, {16'hfe00, 16'hfc00});
		w(`DCFG_OFF_SYNC, 32'h20);
		repeat (4) @(posedge aclk);
		chk({dac_a_out, dac_b_out}, {16'hff00, 16'hfe00});
		w(`DCFG_OFF_CLKPIN, 32'he8);
		repeat (4) @(posedge aclk);
		chk({dac_a_out, dac_b_out}, {16'h0110, 16'h0220});
		w(`DCFG_OFF_CLKPIN, 32'he2);
		repeat (4) @(posedge aclk);
		chk({dac_a_out, dac_b_out}, {16'h00c0, 16'h0200});
		summarize();
	end
endmodule
